// ==== hw/secp_pkg.sv ====
/*
  Shared constants, types and register layout of the serial EEPROM
  command port. Assumes a 20 MHz pclk and a three-wire serial memory
  with byte organisation and nine address bits.
*/
`default_nettype none
package secp_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CMD       = 12'h030;
  localparam logic [11:0] ADDR_DATA      = 12'h034;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'h0F0;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h0F4;
  // Command/status field positions
  localparam int BUSY_BIT   = 31;
  localparam int CMD_HI     = 30;
  localparam int CMD_LO     = 28;
  localparam int TO_BIT     = 10;
  localparam int LOAD_BIT   = 9;
  localparam int ADDR_HI    = 8;
  localparam int DATA_HI    = 7;
  // Interrupt status bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_TO     = 1;
  localparam int IRQ_LOAD   = 2;
  // Reset values
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Valid image marker at memory address zero
  localparam logic [7:0] SIG_VALID = 8'hA5;
  // Frame lengths in serial clocks
  localparam logic [4:0] HDR_BITS  = 5'h0C;
  localparam logic [4:0] WR_BITS   = 5'h14;
  localparam logic [4:0] RD_BITS   = 5'h15;
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int SK_HZ           = 1_000_000;
  localparam int SK_DIV          = CLK_HZ / (2 * SK_HZ);
  localparam int TIMEOUT_MS      = 30;
  localparam int TIMEOUT_CYC_DEF = CLK_HZ / 1000 * TIMEOUT_MS;
  // Poll waits until the input synchroniser has refilled
  localparam logic [19:0] POLL_SETTLE = 20'h00002;

  typedef enum logic [2:0] {
    CMD_READ      = 3'h0,
    CMD_WR_DIS    = 3'h1,
    CMD_WR_EN     = 3'h2,
    CMD_WRITE     = 3'h3,
    CMD_WR_ALL    = 3'h4,
    CMD_ERASE     = 3'h5,
    CMD_ERASE_ALL = 3'h6,
    CMD_RELOAD    = 3'h7
  } secp_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_GAP   = 4'h4,
    ST_POLL  = 4'h8
  } secp_state_e;

  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
  } secp_pins_s;
endpackage
`default_nettype wire

// ==== hw/secp_sync.sv ====
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`default_nettype none
module secp_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // secp_sync
`default_nettype wire

// ==== hw/secp_tick.sv ====
/*
  Divider making a one-cycle enable pulse every DIV cycles.
  Assumes run is synchronous; the count restarts while run is low.
*/
`default_nettype none
module secp_tick #(
  parameter int DIV = 10
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output var  logic tick
);
  localparam logic [7:0] LAST = 8'(DIV - 1);
  logic [7:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt  <= (cnt == LAST) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule // secp_tick
`default_nettype wire

// ==== hw/secp_top.sv ====
/*
  Serial EEPROM command port: APB registers, three-wire serial
  sequencer, response time-out, boot load and interrupt.
  Assumes an APB master on pclk; the serial input pin is asynchronous.
*/
`default_nettype none
// Overview of operation
// - No response in 30 ms aborts to idle
// - Time-out sets sticky flag, host clears
// - Serial input high means no time-out
// - Input high, absent memory: busy clears
// - Only erase and write commands time out
// - Load flag marks valid image loaded
// - Load flag set after boot or reload
// - Nine-bit writable address field, reset zero
// - Address selects one byte location
// - Data register holds one byte
// - Busy set starts command, held until done
// - Three-bit command field decode
// - Reload fails without A5h at zero
// - Busy high from reset until boot load
module secp_top
  import secp_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        ee_di,
  output var  secp_pins_s  ee_out,
  output var  logic        irq
);
  localparam logic [19:0] TO_LAST = 20'(TIMEOUT_CYC - 1);

  secp_state_e st;
  secp_cmd_e   run_cmd, next_cmd;
  logic        di_s, tick, wr, wr_cmd, wr_data, busy, boot_pend;
  logic        to_flag, load_flag, phase, sk_rise, sk_fall, frame_end;
  logic        prog, next_prog, poll_done, to_hit, finish, load_ok;
  logic        mapped;
  logic [2:0]  cmd_f, irq_stat, irq_mask, irq_ev;
  logic [8:0]  addr_f, f_addr;
  logic [7:0]  data_f, rx, f_data;
  logic [19:0] tx, tocnt;
  logic [4:0]  bitcnt, nbits, f_n;
  logic [1:0]  f_op;
  logic [31:0] rdata;

  secp_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ee_di),
    .q     (di_s)
  );

  secp_tick #(.DIV(SK_DIV)) u_tick (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (st != ST_IDLE),
    .tick  (tick)
  );

  // APB decode
  assign wr      = psel & penable & pready & pwrite;
  assign wr_cmd  = wr & (paddr == ADDR_CMD);
  assign wr_data = wr & (paddr == ADDR_DATA);

  // Sequencer events
  assign sk_rise   = tick & ~phase;
  assign sk_fall   = tick & phase;
  assign frame_end = (st == ST_SHIFT) & sk_fall &
                     (bitcnt == nbits - 5'h01);
  assign prog      = (run_cmd == CMD_WRITE) | (run_cmd == CMD_WR_ALL) |
                     (run_cmd == CMD_ERASE) | (run_cmd == CMD_ERASE_ALL);
  assign poll_done = (st == ST_POLL) & di_s &
                     (tocnt >= POLL_SETTLE);
  assign to_hit    = (st == ST_POLL) & ~di_s & (tocnt == TO_LAST);
  assign finish    = (frame_end & ~prog) | poll_done | to_hit;
  assign load_ok   = finish & (run_cmd == CMD_RELOAD) &
                     (rx == SIG_VALID);
  assign next_cmd  = boot_pend ? CMD_RELOAD : secp_cmd_e'(cmd_f);

  // Frame for the command about to start
  always_comb begin
    next_prog = 1'b0;
    f_op      = 2'b00;
    f_addr    = addr_f;
    f_n       = HDR_BITS;
    case (next_cmd)
      CMD_READ: begin
        f_op = 2'b10;
        f_n  = RD_BITS;
      end
      CMD_WR_DIS: f_addr = 9'h000;
      CMD_WR_EN: f_addr = 9'h180;
      CMD_WRITE: begin
        f_op      = 2'b01;
        f_n       = WR_BITS;
        next_prog = 1'b1;
      end
      CMD_WR_ALL: begin
        f_addr    = 9'h080;
        f_n       = WR_BITS;
        next_prog = 1'b1;
      end
      CMD_ERASE: begin
        f_op      = 2'b11;
        next_prog = 1'b1;
      end
      CMD_ERASE_ALL: begin
        f_addr    = 9'h100;
        next_prog = 1'b1;
      end
      default: begin
        f_op   = 2'b10;
        f_addr = 9'h000;
        f_n    = RD_BITS;
      end
    endcase
    f_data = (f_n == WR_BITS) ? data_f : 8'h00;
    if (next_prog && f_n != WR_BITS) begin
      f_data = 8'h00;
    end
  end

  // Serial sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= ST_IDLE;
      run_cmd <= CMD_READ;
      phase   <= 1'b0;
      bitcnt  <= 5'h00;
      nbits   <= 5'h00;
      tx      <= 20'h00000;
      tocnt   <= 20'h00000;
      ee_out  <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (busy) begin
            st      <= ST_SHIFT;
            run_cmd <= next_cmd;
            tx      <= {1'b1, f_op, f_addr, f_data};
            nbits   <= f_n;
            bitcnt  <= 5'h00;
            phase   <= 1'b0;
            ee_out  <= '{cs: 1'b1, sk: 1'b0, dout: 1'b1};
          end
        end
        ST_SHIFT: begin
          if (sk_rise) begin
            ee_out.sk <= 1'b1;
            phase     <= 1'b1;
          end else if (sk_fall) begin
            ee_out.sk <= 1'b0;
            phase     <= 1'b0;
            if (frame_end) begin
              ee_out.cs   <= 1'b0;
              ee_out.dout <= 1'b0;
              st          <= prog ? ST_GAP : ST_IDLE;
            end else begin
              bitcnt      <= bitcnt + 5'h01;
              tx          <= {tx[18:0], 1'b0};
              ee_out.dout <= tx[18];
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            ee_out.cs <= 1'b1;
            tocnt     <= 20'h00000;
            st        <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (poll_done || to_hit) begin
            ee_out.cs <= 1'b0;
            st        <= ST_IDLE;
          end else begin
            tocnt <= tocnt + 20'h00001;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Read data capture on rising serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx <= 8'h00;
    end else if (st == ST_SHIFT && sk_rise && bitcnt >= HDR_BITS) begin
      rx <= {rx[6:0], di_s};
    end
  end

  // Busy and boot load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b1;
      boot_pend <= 1'b1;
    end else if (finish) begin
      busy      <= 1'b0;
      boot_pend <= 1'b0;
    end else if (wr_cmd && !busy && pwdata[BUSY_BIT]) begin
      busy <= 1'b1;
    end
  end

  // Command, address and data fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_f  <= CMD_READ;
      addr_f <= ADDR_RST;
    end else if (wr_cmd && !busy) begin
      cmd_f  <= pwdata[CMD_HI:CMD_LO];
      addr_f <= pwdata[ADDR_HI:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_f <= DATA_RST;
    end else if (finish && run_cmd == CMD_READ) begin
      data_f <= rx;
    end else if (wr_data && !busy) begin
      data_f <= pwdata[DATA_HI:0];
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_flag   <= 1'b0;
      load_flag <= 1'b0;
    end else begin
      to_flag   <= (to_flag & ~(wr_cmd & pwdata[TO_BIT])) | to_hit;
      load_flag <= (load_flag & ~(wr_cmd & pwdata[LOAD_BIT])) |
                   load_ok;
    end
  end

  // Interrupt status, mask and output
  assign irq_ev = {load_ok, to_hit, finish};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      irq_mask <= MASK_RST;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat &
                   ~({3{wr & (paddr == ADDR_IRQ_STAT)}} & pwdata[2:0])) |
                  irq_ev;
      if (wr && paddr == ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[2:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read mux
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h00000000;
    if (paddr == ADDR_CMD) begin
      rdata = {busy, cmd_f, 17'h00000, to_flag, load_flag, addr_f};
    end else if (paddr == ADDR_DATA) begin
      rdata = {24'h000000, data_f};
    end else if (paddr == ADDR_IRQ_STAT) begin
      rdata = {29'h00000000, irq_stat};
    end else if (paddr == ADDR_IRQ_MASK) begin
      rdata = {29'h00000000, irq_mask};
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_cmd_wr; wr_cmd && !busy; endsequence

  property p_apb_answer; s_setup ##1 s_wait |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late");
  property p_abort; to_hit |=> st == ST_IDLE && !ee_out.cs; endproperty
  a_abort: assert property (p_abort)
    else $error("no abort on time-out");
  property p_to_flag; to_hit |=> to_flag; endproperty
  a_to_flag: assert property (p_to_flag)
    else $error("time-out flag not set");
  property p_high_in;
    st == ST_POLL && di_s && tocnt >= POLL_SETTLE |=>
      st == ST_IDLE ##0 !$rose(to_flag);
  endproperty
  a_high_in: assert property (p_high_in)
    else $error("timed out with input high");
  property p_poll_settle;
    st == ST_POLL && tocnt < POLL_SETTLE |=> st == ST_POLL;
  endproperty
  a_poll_settle: assert property (p_poll_settle)
    else $error("poll ended before input settled");
  property p_busy_clear; frame_end && !prog |=> !busy; endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared at frame end");
  property p_to_prog; to_hit |-> prog; endproperty
  a_to_prog: assert property (p_to_prog)
    else $error("non-program command timed out");
  property p_load_src; $rose(load_flag) |-> $past(load_ok); endproperty
  a_load_src: assert property (p_load_src)
    else $error("load flag without good load");
  property p_addr_wr; s_cmd_wr |=> addr_f == $past(pwdata[8:0]); endproperty
  a_addr_wr: assert property (p_addr_wr)
    else $error("address field not written");
  property p_data_upper;
    pready && !pwrite && paddr == ADDR_DATA |-> prdata[31:8] == 24'h0;
  endproperty
  a_data_upper: assert property (p_data_upper)
    else $error("data upper bits not zero");
  property p_busy_hold; st != ST_IDLE |-> busy; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy low during operation");
  property p_bad_image;
    finish && run_cmd == CMD_RELOAD && rx != SIG_VALID |=>
      !$rose(load_flag);
  endproperty
  a_bad_image: assert property (p_bad_image)
    else $error("load flag set on bad image");
  property p_boot_busy; boot_pend |-> busy; endproperty
  a_boot_busy: assert property (p_boot_busy)
    else $error("busy low before boot load");
  property p_sk_cs; $rose(ee_out.sk) |-> ee_out.cs; endproperty
  a_sk_cs: assert property (p_sk_cs)
    else $error("serial clock without select");
endmodule // secp_top
`default_nettype wire

// ==== verification/secp_eeprom_model.sv ====
/*
  Behavioural three-wire serial memory of 512 bytes.
  Assumes a high-active select; an idle input line sits at pull.
*/
`default_nettype none
module secp_eeprom_model
  import secp_pkg::*;
(
  input  wire logic       clk,
  input  wire secp_pins_s pins,
  input  wire logic       present,
  input  wire logic       pull,
  input  wire logic [7:0] prog_cyc,
  output var  logic       di
);
  logic [7:0]  mem [512];
  logic [19:0] sh;
  logic [7:0]  rdb;
  logic [1:0]  op;
  logic        wen, pg, drv, dval;
  int          n, busy;

  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    mem[0] = SIG_VALID;
    wen = 0;
    pg = 0;
    drv = 0;
    dval = 0;
    busy = 0;
  end

  // Released or deselected line falls to its pull level
  assign di = (present && pins.cs && drv) ? dval : pull;

  task automatic prog(input int ad, input logic [7:0] v, input logic all);
    if (wen) begin
      for (int i = 0; i < 512; i++) if (all || i == ad) mem[i] = v;
      busy = prog_cyc + 1;
      pg = 1;
    end
  endtask

  // Low while programming, high once ready
  always @(posedge pins.cs) begin
    n = 0;
    drv = pg;
    dval = (busy == 0);
  end
  always @(negedge pins.cs) begin
    if (drv) pg = 0;
    drv = 0;
  end
  always @(posedge clk) begin
    if (busy > 0) busy = busy - 1;
    if (pg && drv) dval = (busy == 0);
  end

  // Start bit, opcode, address, then data
  always @(posedge pins.sk) if (pins.cs && present) begin
    sh = {sh[18:0], pins.dout};
    n = n + 1;
    if (n == 3) op = sh[1:0];
    if (n == 12) begin
      rdb = mem[sh[8:0]];
      if (op == 2'b11) prog(sh[8:0], 8'hFF, 0);
      if (op == 2'b00) case (sh[8:7])
        2'b11: wen = 1;
        2'b00: wen = 0;
        2'b10: prog(0, 8'hFF, 1);
        default: ;
      endcase
    end
    if (n == 20 && op == 2'b01) prog(sh[16:8], sh[7:0], 0);
    if (n == 20 && op == 2'b00 && sh[16:15] == 2'b01) prog(0, sh[7:0], 1);
  end

  // Dummy zero, then read byte MSB first
  always @(negedge pins.sk) begin
    if (pins.cs && op == 2'b10 && n >= 12 && n <= 20) begin
      drv = 1;
      dval = (n == 12) ? 1'b0 : rdb[20 - n];
    end
  end
endmodule // secp_eeprom_model
`default_nettype wire

// ==== verification/serial_eeprom_cmd_port_tb_top.sv ====
/*
  Self-checking bench of the serial EEPROM command port.
  Assumes the serial memory model beside it and a 20 MHz pclk.
*/
`default_nettype none
module serial_eeprom_cmd_port_tb_top
  import secp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO_CYC = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ee_di, irq, present, pull, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  a;
  logic [7:0]  d, prog_cyc;
  secp_pins_s  ee_out;
  int          mismatches, check_count, cyc;

  secp_top #(.TIMEOUT_CYC(TO_CYC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ee_di(ee_di), .ee_out(ee_out),
    .irq(irq));
  secp_eeprom_model i_mem (.clk(pclk), .pins(ee_out), .present(present),
    .pull(pull), .prog_cyc(prog_cyc), .di(ee_di));

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] v);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(0, ADDR_CMD, 32'h0);
      k++;
    end while (rd[BUSY_BIT] !== 1'b0 && k < 400);
    chk("busy", rd[BUSY_BIT], 0);
  endtask

  task automatic run(input logic [2:0] c, input logic [8:0] ad);
    prog_cyc <= 8'($urandom_range(150, 2));
    apb(1, ADDR_CMD, {1'b1, c, 19'h0, ad});
    wait_idle();
  endtask

  task automatic rdmem(input logic [8:0] ad, input logic [7:0] v);
    run(CMD_READ, ad);
    apb(0, ADDR_DATA, 32'h0);
    chk("data", rd, {24'h0, v});
  endtask

  function automatic logic exp_to(input int c, input logic lvl);
    return !lvl && c >= 3 && c <= 6;
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, mismatches, check_count, cyc} = '0;
    present = 1;
    pull = 1;
    prog_cyc = 8'h10;
    void'($urandom(36186));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, ADDR_CMD, 32'h0);
    chk("boot busy", rd[BUSY_BIT], 1);
    wait_idle();
    chk("loaded", rd[LOAD_BIT], 1);
    chk("addr rst", rd[ADDR_HI:0], 0);
    apb(0, ADDR_DATA, 32'h0);
    chk("data rst", rd, 0);
    apb(0, ADDR_IRQ_STAT, 32'h0);
    chk("load event", rd[IRQ_LOAD], 1);
    apb(1, ADDR_CMD, 32'h200);
    apb(0, ADDR_CMD, 32'h0);
    chk("loaded clr", rd[LOAD_BIT], 0);
    apb(0, 12'h038, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    run(CMD_WR_EN, 9'h180);
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom_range(511, 1));
      d = 8'($urandom);
      apb(1, ADDR_DATA, {24'hFFFFFF, d});
      run(CMD_WRITE, a);
      chk("addr", rd[ADDR_HI:0], a);
      chk("no timeout", rd[TO_BIT], 0);
      apb(1, ADDR_DATA, 32'h0);
      rdmem(a, d);
      chk("cell", i_mem.mem[a], d);
    end
    apb(1, ADDR_CMD, {1'b1, CMD_READ, 19'h0, a});
    apb(1, ADDR_CMD, {4'h0, 19'h0, ~a});
    wait_idle();
    chk("locked addr", rd[ADDR_HI:0], a);
    apb(1, ADDR_DATA, 32'h5A);
    run(CMD_WR_ALL, 9'h080);
    rdmem(9'($urandom), 8'h5A);
    run(CMD_ERASE, a);
    rdmem(a, 8'hFF);
    apb(1, ADDR_DATA, 32'h33);
    run(CMD_WRITE, a);
    run(CMD_ERASE_ALL, 9'h100);
    rdmem(a ^ 9'h1, 8'hFF);
    run(CMD_WR_DIS, 9'h000);
    apb(1, ADDR_DATA, 32'h33);
    run(CMD_WRITE, a);
    rdmem(a, 8'hFF);
    i_mem.mem[0] = 8'h3C;
    apb(1, ADDR_DATA, 32'h77);
    run(CMD_RELOAD, 9'h0);
    chk("bad reload", rd[LOAD_BIT], 0);
    i_mem.mem[0] = SIG_VALID;
    run(CMD_RELOAD, 9'h0);
    chk("reload", rd[LOAD_BIT], 1);
    apb(0, ADDR_DATA, 32'h0);
    chk("data kept", rd, 32'h77);
    apb(1, ADDR_IRQ_MASK, 32'h2);
    present = 0;
    for (int lv = 0; lv < 2; lv++) begin
      pull = lv[0];
      for (int c = 0; c < 8; c++) begin
        run(3'(c), 9'(c));
        chk("timeout", rd[TO_BIT], exp_to(c, pull));
        chk("irq", irq, exp_to(c, pull));
        apb(1, ADDR_IRQ_STAT, 32'h7);
        apb(1, ADDR_CMD, 32'h400);
        apb(0, ADDR_CMD, 32'h0);
        chk("timeout clr", rd[TO_BIT], 0);
        chk("irq clr", irq, 0);
      end
    end
    close_out();
  end
endmodule // serial_eeprom_cmd_port_tb_top
`default_nettype wire
